// ===== pkg/sdhc_pkg.sv
// constants, timing and types shared by the sdram host controller
package sdhc_pkg;
  localparam int OPERATING_FREQUENCY_MHZ = 50;
  localparam int BA_W = 2;
  localparam int NBANKS = 4;

  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * OPERATING_FREQUENCY_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int cyc_max(input int ns);
    int c;
    c = (ns * OPERATING_FREQUENCY_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_RP_NS   = 20;
  localparam int T_RCD_NS  = 20;
  localparam int T_RAS_NS  = 45;
  localparam int T_WR_NS   = 30;
  localparam int T_RFC_NS  = 70;
  localparam int T_MRD_NS  = 30;
  localparam int T_XSR_NS  = 80;
  localparam int T_REFI_NS = 15625;
  localparam int T_INIT_NS = 200000;
  localparam int CYC_RP    = cyc_min(T_RP_NS);
  localparam int CYC_RCD   = cyc_min(T_RCD_NS);
  localparam int CYC_RAS   = cyc_min(T_RAS_NS);
  localparam int CYC_WR    = cyc_min(T_WR_NS);
  localparam int CYC_RFC   = cyc_min(T_RFC_NS);
  localparam int CYC_MRD   = cyc_min(T_MRD_NS);
  localparam int CYC_XSR   = cyc_min(T_XSR_NS);
  localparam int CYC_REFI  = cyc_max(T_REFI_NS);
  localparam int CYC_INIT  = cyc_min(T_INIT_NS);

  localparam logic [3:0] INIT_REFS = 4'h8;
  // cas latency two plus pad and capture registers
  localparam int RD_LAT = 4;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // burst of one, cas latency two
  localparam logic [11:0] MODE_WORD   = 12'h020;
  localparam int          PRE_ALL_BIT = 10;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_IDLE = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam int          CTRL_SR_EN     = 0;
  localparam logic        CTRL_SR_EN_RST = 1'b1;
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_PEND      = 4;
  localparam int          STAT_SREF      = 5;
  localparam int          STAT_READY     = 6;

  typedef enum logic [3:0] {
    ST_INIT_WAIT = 4'h0,
    ST_INIT_PRE  = 4'h1,
    ST_INIT_REF  = 4'h2,
    ST_INIT_MRS  = 4'h3,
    ST_READY     = 4'h4,
    ST_PRE       = 4'h5,
    ST_ACT       = 4'h6,
    ST_REF       = 4'h7,
    ST_SREF      = 4'h8,
    ST_SREF_EXIT = 4'h9
  } sdhc_state_e;
endpackage

// ===== rtl/sdhc_ahb_regs.sv
// ahb-lite register slave: control, idle limit and status
module sdhc_ahb_regs #(
  parameter int                IDLE_W   = 16,
  parameter logic [IDLE_W-1:0] IDLE_RST = 16'h2710
) (
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // controller side
  input  wire logic [31:0]       stat_word,
  output logic                   sr_enable,
  output logic [IDLE_W-1:0]      idle_limit
);
  logic        wr_pend_r;
  logic [11:0] wa_r;
  logic [31:0] hrdata_r;
  logic        sr_en_r;
  logic [IDLE_W-1:0] idle_r;
  logic        take;

  // only whole words are used, so the transfer size is not decoded
  assign take      = hsel && htrans[1] && hready && ce;
  // a frozen controller stalls the bus instead of dropping transfers
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign sr_enable = sr_en_r;
  assign idle_limit = idle_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 12'h000;
    end else if (ce && hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wa_r      <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_en_r <= sdhc_pkg::CTRL_SR_EN_RST;
      idle_r  <= IDLE_RST;
    end else if (ce && wr_pend_r) begin
      if (wa_r == sdhc_pkg::REG_CTRL) sr_en_r <= hwdata[sdhc_pkg::CTRL_SR_EN];
      if (wa_r == sdhc_pkg::REG_IDLE) idle_r <= hwdata[IDLE_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[11:0])
        sdhc_pkg::REG_CTRL: hrdata_r <= {31'h0000_0000, sr_en_r};
        sdhc_pkg::REG_IDLE: hrdata_r <= 32'(idle_r);
        sdhc_pkg::REG_STAT: hrdata_r <= stat_word;
        default:            hrdata_r <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ===== rtl/sdhc_top.sv
// sdram host controller: request handling, sdram sequencing, refresh
// How it works
// - pipelined mode issues in-row accesses every cycle
// - track open row per bank, or one
// - idle count reaching limit enters self-refresh
// - periodic auto-refresh keeps data valid
// - word width and geometry are parameters
// - reset clears logic and starts sdram initialisation
// - registered op-started marks initiation
// - lookahead is high the cycle before op-started
// - reads-outstanding high while reads await data
// - done pulses one cycle on writes, and on read completion when not pipelined
// - pipelined read completion pulses one cycle
// - address splits bank, row, column top down
// - bank select and row/column address driven
// - data drive only with valid write word
// - upper and lower data masks driven
// - miss or refresh: precharge, activate, hold starts
// - non-pipelined write done with op-started
// - write waits for outstanding reads
//
// The address map and the AHB-Lite slave port were left to the implementer.
module sdhc_top #(
  parameter bit   PIPELINE_EN                     = 1'b1,
  parameter bit   PER_BANK_ROW_TRACKING           = 1'b1,
  parameter int   DATA_WIDTH                      = 16,
  parameter int   ROWS_PER_BANK                   = 4096,
  parameter int   COLUMNS_PER_ROW                 = 512,
  parameter int   IDLE_CYCLES_BEFORE_SELF_REFRESH = 10000,
  parameter int   INIT_CYC                        = sdhc_pkg::CYC_INIT,
  localparam int  ROW_W   = $clog2(ROWS_PER_BANK),
  localparam int  COL_W   = $clog2(COLUMNS_PER_ROW),
  localparam int  HADDR_W = sdhc_pkg::BA_W + ROW_W + COL_W,
  localparam int  SA_W    = ROW_W
) (
  // clock, reset, enable
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  input  wire logic                   clk_stable,
  // host request
  input  wire logic                   rd_req,
  input  wire logic                   wr_req,
  input  wire logic [HADDR_W-1:0]     host_addr,
  input  wire logic [DATA_WIDTH-1:0]  host_write_data,
  // host answer
  output logic                        op_started,
  output logic                        op_start_lookahead,
  output logic                        reads_outstanding,
  output logic                        done,
  output logic                        pipelined_read_complete,
  output logic [DATA_WIDTH-1:0]       host_read_data,
  output logic [3:0]                  status,
  // sdram
  output logic                        mem_cke,
  output logic                        mem_cs_n,
  output logic                        mem_ras_n,
  output logic                        mem_cas_n,
  output logic                        mem_we_n,
  output logic [sdhc_pkg::BA_W-1:0]   mem_ba,
  output logic [SA_W-1:0]             mem_address_out,
  input  wire logic [DATA_WIDTH-1:0]  mem_data_in,
  output logic [DATA_WIDTH-1:0]       mem_data_out,
  output logic                        mem_data_drive,
  output logic                        mem_dqmh,
  output logic                        mem_dqml,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata
);
  localparam int IDLE_W = 16;
  localparam int INIT_W = $clog2(INIT_CYC + 1);
  localparam int REFI_W = $clog2(sdhc_pkg::CYC_REFI + 1);
  localparam int NB     = sdhc_pkg::NBANKS;

  sdhc_pkg::sdhc_state_e st_r;
  logic [7:0]            tmr_r, pre_tmr_r;
  logic [3:0]            cmd_r, refs_left_r;
  logic                  cke_r, dqm_r, drive_r, op_started_r, done_r, rdc_r;
  logic [sdhc_pkg::BA_W-1:0] ba_r;
  logic [SA_W-1:0]       addr_r;
  logic [DATA_WIDTH-1:0] dout_r, rdata_r;
  logic [INIT_W-1:0]     init_cnt_r;
  logic [REFI_W-1:0]     ref_cnt_r;
  logic                  ref_due_r;
  logic [IDLE_W-1:0]     idle_cnt_r, idle_limit;
  logic                  sr_enable;
  logic [sdhc_pkg::RD_LAT-1:0] rd_pipe_r;
  logic                  pend_r;
  logic [ROW_W-1:0]      open_row_r [NB];
  logic [NB-1:0]         open_vld_r;
  logic [31:0]           stat_word;

  logic [sdhc_pkg::BA_W-1:0] bank;
  logic [ROW_W-1:0]      row;
  logic [COL_W-1:0]      col;
  logic                  req, is_wr, hit, tmr0, sr_go, can_go;
  logic                  issue, pre_fire, act_fire, ref_fire, in_svc;

  // bank on top, then row, column in the low bits
  assign bank  = host_addr[HADDR_W-1 -: sdhc_pkg::BA_W];
  assign row   = host_addr[COL_W +: ROW_W];
  assign col   = host_addr[COL_W-1:0];
  assign req   = rd_req || wr_req;
  // a read wins when both are raised
  assign is_wr = wr_req && !rd_req;
  assign hit   = open_vld_r[bank] && (open_row_r[bank] == row);
  assign tmr0  = (tmr_r == 8'h00);
  assign sr_go = sr_enable && !req && !pend_r && (idle_cnt_r >= idle_limit);
  assign can_go = is_wr ? !pend_r : (PIPELINE_EN || !pend_r);
  assign issue = ce && (st_r == sdhc_pkg::ST_READY) && tmr0 && !ref_due_r && !sr_go
               && req && hit && can_go;
  assign pre_fire = ce && (st_r == sdhc_pkg::ST_READY) && tmr0 && (pre_tmr_r == 8'h00)
                  && !pend_r && (ref_due_r || sr_go || (req && !hit));
  assign act_fire = ce && (st_r == sdhc_pkg::ST_PRE) && tmr0 && !ref_due_r && !sr_go && req;
  assign ref_fire = ce && (st_r == sdhc_pkg::ST_PRE) && tmr0 && ref_due_r;
  assign in_svc = (st_r == sdhc_pkg::ST_READY) || (st_r == sdhc_pkg::ST_PRE)
               || (st_r == sdhc_pkg::ST_ACT) || (st_r == sdhc_pkg::ST_REF)
               || (st_r == sdhc_pkg::ST_SREF_EXIT);

  assign op_start_lookahead = issue;
  assign op_started = op_started_r;
  assign reads_outstanding = pend_r;
  assign done = done_r;
  assign pipelined_read_complete = rdc_r;
  assign host_read_data = rdata_r;
  assign status = st_r;
  assign mem_cke = cke_r;
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd_r;
  assign mem_ba = ba_r;
  assign mem_address_out = addr_r;
  assign mem_data_out = dout_r;
  assign mem_data_drive = drive_r;
  assign mem_dqmh = dqm_r;
  assign mem_dqml = dqm_r;

  // command sequencer; reset lands in the init wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r        <= sdhc_pkg::ST_INIT_WAIT;
      cmd_r       <= sdhc_pkg::CMD_NOP;
      cke_r       <= 1'b0;
      ba_r        <= '0;
      addr_r      <= '0;
      tmr_r       <= 8'h00;
      pre_tmr_r   <= 8'h00;
      init_cnt_r  <= '0;
      refs_left_r <= 4'h0;
    end else if (ce) begin
      cmd_r <= sdhc_pkg::CMD_NOP;
      if (!tmr0) tmr_r <= tmr_r - 8'h01;
      if (pre_tmr_r != 8'h00) pre_tmr_r <= pre_tmr_r - 8'h01;
      case (st_r)
        sdhc_pkg::ST_INIT_WAIT: begin
          if (clk_stable) begin
            cke_r <= 1'b1;
            if (init_cnt_r != INIT_W'(INIT_CYC)) begin
              init_cnt_r <= init_cnt_r + INIT_W'(1);
            end else begin
              cmd_r  <= sdhc_pkg::CMD_PRE;
              addr_r <= SA_W'(1) << sdhc_pkg::PRE_ALL_BIT;
              tmr_r  <= 8'(sdhc_pkg::CYC_RP - 1);
              st_r   <= sdhc_pkg::ST_INIT_PRE;
            end
          end
        end
        sdhc_pkg::ST_INIT_PRE, sdhc_pkg::ST_INIT_REF: begin
          if (tmr0) begin
            if (st_r == sdhc_pkg::ST_INIT_PRE || refs_left_r != 4'h0) begin
              cmd_r       <= sdhc_pkg::CMD_REF;
              tmr_r       <= 8'(sdhc_pkg::CYC_RFC - 1);
              refs_left_r <= (st_r == sdhc_pkg::ST_INIT_PRE) ?
                             sdhc_pkg::INIT_REFS - 4'h1 : refs_left_r - 4'h1;
              st_r        <= sdhc_pkg::ST_INIT_REF;
            end else begin
              cmd_r  <= sdhc_pkg::CMD_MRS;
              ba_r   <= '0;
              addr_r <= SA_W'(sdhc_pkg::MODE_WORD);
              tmr_r  <= 8'(sdhc_pkg::CYC_MRD - 1);
              st_r   <= sdhc_pkg::ST_INIT_MRS;
            end
          end
        end
        sdhc_pkg::ST_READY: begin
          if (pre_fire) begin
            cmd_r  <= sdhc_pkg::CMD_PRE;
            addr_r <= SA_W'(1) << sdhc_pkg::PRE_ALL_BIT;
            tmr_r  <= 8'(sdhc_pkg::CYC_RP - 1);
            st_r   <= sdhc_pkg::ST_PRE;
          end else if (issue) begin
            cmd_r  <= is_wr ? sdhc_pkg::CMD_WR : sdhc_pkg::CMD_RD;
            ba_r   <= bank;
            addr_r <= SA_W'(col);
            if (is_wr) pre_tmr_r <= 8'(sdhc_pkg::CYC_WR);
          end
        end
        sdhc_pkg::ST_PRE: begin
          if (ref_fire) begin
            cmd_r <= sdhc_pkg::CMD_REF;
            tmr_r <= 8'(sdhc_pkg::CYC_RFC - 1);
            st_r  <= sdhc_pkg::ST_REF;
          end else if (tmr0 && sr_go) begin
            cmd_r <= sdhc_pkg::CMD_REF;
            cke_r <= 1'b0;
            st_r  <= sdhc_pkg::ST_SREF;
          end else if (act_fire) begin
            cmd_r     <= sdhc_pkg::CMD_ACT;
            ba_r      <= bank;
            addr_r    <= SA_W'(row);
            tmr_r     <= 8'(sdhc_pkg::CYC_RCD - 1);
            pre_tmr_r <= 8'(sdhc_pkg::CYC_RAS - 1);
            st_r      <= sdhc_pkg::ST_ACT;
          end else if (tmr0) begin
            st_r <= sdhc_pkg::ST_READY;
          end
        end
        sdhc_pkg::ST_SREF: begin
          if (req) begin
            cke_r <= 1'b1;
            tmr_r <= 8'(sdhc_pkg::CYC_XSR - 1);
            st_r  <= sdhc_pkg::ST_SREF_EXIT;
          end
        end
        sdhc_pkg::ST_INIT_MRS, sdhc_pkg::ST_ACT, sdhc_pkg::ST_REF,
        sdhc_pkg::ST_SREF_EXIT: begin
          if (tmr0) st_r <= sdhc_pkg::ST_READY;
        end
        default: st_r <= sdhc_pkg::ST_INIT_WAIT;
      endcase
    end
  end

  // open-row table; precharge is always to all banks
  for (genvar b = 0; b < NB; b++) begin : g_row
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        open_vld_r[b] <= 1'b0;
        open_row_r[b] <= '0;
      end else if (pre_fire) begin
        open_vld_r[b] <= 1'b0;
      end else if (act_fire) begin
        if (bank == b) begin
          open_vld_r[b] <= 1'b1;
          open_row_r[b] <= row;
        end else if (!PER_BANK_ROW_TRACKING) begin
          open_vld_r[b] <= 1'b0;
        end
      end
    end
  end

  // refresh interval; a due flag set in the clearing cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_r <= REFI_W'(sdhc_pkg::CYC_REFI);
      ref_due_r <= 1'b0;
    end else if (ce) begin
      if (ref_fire) ref_due_r <= 1'b0;
      if (!in_svc) begin
        ref_cnt_r <= REFI_W'(sdhc_pkg::CYC_REFI);
      end else if (ref_cnt_r == '0) begin
        ref_cnt_r <= REFI_W'(sdhc_pkg::CYC_REFI);
        ref_due_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r - REFI_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_r <= '0;
    end else if (ce) begin
      if (req) idle_cnt_r <= '0;
      else if (idle_cnt_r != '1) idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
    end
  end

  // read return pipe and host answers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pipe_r    <= '0;
      pend_r       <= 1'b0;
      op_started_r <= 1'b0;
      done_r       <= 1'b0;
      rdc_r        <= 1'b0;
      rdata_r      <= '0;
    end else if (ce) begin
      rd_pipe_r    <= {rd_pipe_r[sdhc_pkg::RD_LAT-2:0], issue && !is_wr};
      pend_r       <= (|rd_pipe_r[sdhc_pkg::RD_LAT-2:0]) || (issue && !is_wr);
      op_started_r <= issue;
      done_r <= (issue && is_wr) || (!PIPELINE_EN && rd_pipe_r[sdhc_pkg::RD_LAT-1]);
      rdc_r  <= PIPELINE_EN && rd_pipe_r[sdhc_pkg::RD_LAT-1];
      if (rd_pipe_r[sdhc_pkg::RD_LAT-1]) rdata_r <= mem_data_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_r <= 1'b0;
      dout_r  <= '0;
      dqm_r   <= 1'b1;
    end else if (ce) begin
      drive_r <= issue && is_wr;
      if (issue && is_wr) dout_r <= host_write_data;
      // masks high while the sdram is not in normal service
      dqm_r <= !in_svc;
    end
  end

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[sdhc_pkg::STAT_STATE_LSB +: 4] = st_r;
    stat_word[sdhc_pkg::STAT_PEND]  = pend_r;
    stat_word[sdhc_pkg::STAT_SREF]  = (st_r == sdhc_pkg::ST_SREF);
    stat_word[sdhc_pkg::STAT_READY] = in_svc;
  end

  sdhc_ahb_regs #(
    .IDLE_W   (IDLE_W),
    .IDLE_RST (IDLE_W'(IDLE_CYCLES_BEFORE_SELF_REFRESH))
  ) u_regs (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .hrdata     (hrdata),
    .stat_word  (stat_word),
    .sr_enable  (sr_enable),
    .idle_limit (idle_limit)
  );

  early_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    op_start_lookahead |=> op_started)
    else $error("op_started did not follow lookahead");
  write_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (issue && is_wr) |=> (done && op_started && mem_data_drive))
    else $error("write done not with op_started");
  read_lat_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (issue && !is_wr && ce) ##1 ce[*4] |=> (done || pipelined_read_complete))
    else $error("read completion not four cycles after start");
  pending_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (issue && !is_wr) |=> reads_outstanding [*3])
    else $error("reads_outstanding dropped early");
  drive_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_data_drive |-> (cmd_r == sdhc_pkg::CMD_WR))
    else $error("data driven without write command");
  miss_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (req && !hit) |-> !op_start_lookahead ##1 !op_started)
    else $error("start raised on row miss");
  write_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_req && !rd_req && reads_outstanding) |-> !op_start_lookahead)
    else $error("write started over pending read");
  sref_cke_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == sdhc_pkg::ST_SREF) |-> (!mem_cke && ($past(cmd_r) != sdhc_pkg::CMD_ACT)))
    else $error("self-refresh with clock enable high");
  refresh_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(ref_due_r) && ce && (st_r != sdhc_pkg::ST_SREF)) |-> ##[1:20]
    (cmd_r == sdhc_pkg::CMD_REF && mem_cke))
    else $error("refresh not issued in time");
endmodule

// ===== tb/sdhc_mem_model.sv
// behavioural sdram: word store and cas-latency read return
module sdhc_mem_model (
  // sdram command side
  input  wire logic        hclk,
  input  wire logic [3:0]  cmd,
  input  wire logic [1:0]  ba,
  input  wire logic [11:0] sa,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_drive,
  // read return
  output logic [15:0]      dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [7:0]  a1, a2, a3;
  logic [2:0]  v = 3'b000;
  logic [15:0] last = 16'h0000;
  always @(posedge hclk) begin
    if (cmd == sdhc_pkg::CMD_WR && dq_drive) mem[{ba, sa[5:0]}] <= dq_out;
    v <= {v[1:0], cmd == sdhc_pkg::CMD_RD};
    a1 <= {ba, sa[5:0]};
    a2 <= a1;
    a3 <= a2;
    if (v[2]) last <= dq_in;
  end
  // released bus shows the inverse of the last word, never a stale copy
  assign dq_in = v[2] ? mem[a3] : ~last;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the sdram host controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, clk_stable = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
  logic [22:0] host_addr = '0;
  logic [15:0] host_write_data = '0, host_read_data, mem_data_in, mem_data_out;
  logic op_started, op_start_lookahead, reads_outstanding, done, pipelined_read_complete;
  logic [3:0] status;
  logic mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_data_drive, mem_dqmh, mem_dqml;
  logic [1:0] mem_ba, htrans = 2'b00;
  logic [11:0] mem_address_out;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [15:0] r;
  int errors = 0, n_compared = 0, n;
  always #10 hclk = ~hclk;
  sdhc_top #(.INIT_CYC(20)) dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .clk_stable(clk_stable), .rd_req(rd_req), .wr_req(wr_req), .host_addr(host_addr),
    .host_write_data(host_write_data), .op_started(op_started),
    .op_start_lookahead(op_start_lookahead), .reads_outstanding(reads_outstanding),
    .done(done), .pipelined_read_complete(pipelined_read_complete),
    .host_read_data(host_read_data), .status(status), .mem_cke(mem_cke),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
    .mem_ba(mem_ba), .mem_address_out(mem_address_out), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_drive(mem_data_drive), .mem_dqmh(mem_dqmh),
    .mem_dqml(mem_dqml), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata));
  sdhc_mem_model mem (.hclk(hclk), .cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}),
    .ba(mem_ba), .sa(mem_address_out), .dq_out(mem_data_out), .dq_drive(mem_data_drive),
    .dq_in(mem_data_in));
  task automatic results;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    for (int i = 0; i < lim && status !== s; i++) @(negedge hclk);
    if (status !== s) begin
      errors++;
      results();
    end
  endtask
  task automatic rdy;
    for (int i = 0; i < 50 && hready !== 1'b1; i++) @(posedge hclk);
    if (hready !== 1'b1) begin
      errors++;
      results();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    rdy();
    q = hrdata;
  endtask
  // one host word; n counts stall cycles before the lookahead
  task automatic hop(input logic w, input logic [22:0] a, input logic [15:0] d);
    int i;
    n = 0;
    @(posedge hclk);
    rd_req <= !w;
    wr_req <= w;
    host_addr <= a;
    host_write_data <= d;
    @(negedge hclk);
    while (op_start_lookahead !== 1'b1 && n < 100) begin
      n++;
      @(negedge hclk);
    end
    if (n == 100) begin
      errors++;
      results();
    end
    @(posedge hclk);
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    @(negedge hclk);
    chk(op_started, 1'b1);
    chk({mem_dqmh, mem_dqml}, 2'b00);
    if (w) chk({done, mem_data_drive}, 2'b11);
    else begin
      chk(reads_outstanding, 1'b1);
      for (i = 0; i < 20 && pipelined_read_complete !== 1'b1; i++) @(negedge hclk);
      chk(i, 4);
      chk(reads_outstanding, 1'b0);
      r = host_read_data;
    end
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (30) @(posedge hclk);
    @(negedge hclk);
    chk({status, mem_cke, mem_dqmh, mem_dqml}, {4'h0, 1'b0, 2'b11});
    @(posedge hclk);
    clk_stable <= 1'b1;
    wait_st(4'h4, 400);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    chk(hresp, 1'b0);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(q, 32'h0000_2710);
    ahb(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    hop(1'b1, {2'd1, 12'd5, 9'd3}, 16'hA5C3);
    chk(n, 3);
    hop(1'b1, {2'd1, 12'd5, 9'd4}, 16'h5A3C);
    chk(n, 0);
    hop(1'b1, {2'd2, 12'd9, 9'd7}, 16'h1234);
    hop(1'b0, {2'd1, 12'd5, 9'd3}, 16'h0000);
    chk(r, 16'hA5C3);
    hop(1'b0, {2'd1, 12'd5, 9'd4}, 16'h0000);
    chk(n, 32'h0000_0000);
    chk(r, 16'h5A3C);
    wait_st(4'h7, 800);
    ahb(1'b1, 32'h0000_0004, 32'h0000_0032);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(q, 32'h0000_0032);
    wait_st(4'h8, 900);
    chk(mem_cke, 1'b0);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk(q, 32'h0000_0028);
    chk({mem_dqmh, mem_dqml}, 2'b11);
    hop(1'b0, {2'd2, 12'd9, 9'd7}, 16'h0000);
    chk(r, 16'h1234);
    results();
  end
endmodule
